// *** rtl/pwm_logic_cfg.svh ***
// Register map, field positions, reset values and timing counts of the
// PWM generator and logic block. Assumes nothing beyond a 20 MHz core clock.
`ifndef PWM_LOGIC_CFG_SVH
`define PWM_LOGIC_CFG_SVH

`define ADDR_OFF_LO      8'h2F
`define ADDR_OFF_HI      8'h30
`define ADDR_ON_LO       8'h31
`define ADDR_ON_HI       8'h32
`define ADDR_PWM_CFG     8'h33
`define ADDR_FUNC_CFG    8'h34
`define ADDR_FLOP_CTL    8'h35
`define ADDR_EVT_CTL     8'h36
`define ADDR_PIN_EXT     8'h3A

`define RST_BYTE         8'h00
`define RST_COUNT        16'h0000
`define RST_SEL          3'h0
`define RST_PIN_ALT      2'h0

`define BIT_PWM_EN       0
`define BIT_RES_INV      6
`define BIT_C_INV        5
`define BIT_B_INV        4
`define BIT_A_INV        3
`define SEL_HI           2
`define BIT_FLOP_SET     1
`define BIT_FLOP_CLR     0
`define BIT_DBNC_BYP     2
`define BIT_EVT_EN       1
`define BIT_INT_LVL      0
`define R3_HI            3
`define R3_LO            2
`define BIT_R0_ALT       0

`define SEL_OFF          3'h0
`define SEL_AND          3'h1
`define SEL_OR           3'h2
`define SEL_XOR          3'h3
`define SEL_FLOP         3'h4
`define SEL_PASS_A       3'h5
`define SEL_PASS_B       3'h6
`define SEL_PASS_C       3'h7

`define R3_AS_INPUT_C    2'h1
`define R3_AS_PWM        2'h2

`define CLK_PERIOD_NS    50
`define PWM_STEP_NS      2000
`define PWM_STEP_CYCLES  (`PWM_STEP_NS / `CLK_PERIOD_NS)
`define DBNC_STEPS       4'h4

`endif

// *** rtl/pwm_logic_pkg.sv ***
// Types shared by the PWM generator and logic block.
// Assumes the register port is driven by the expander's serial interface logic.
package pwm_logic_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef enum logic [1:0] {
    PWM_IDLE,
    PWM_HIGH,
    PWM_LOW
  } pwm_state_type;

endpackage

// *** rtl/pwm_logic_block.sv ***
// PWM generator and three-input programmable logic block with pin routing.
// Assumes a 20 MHz core clock, one-cycle register strobes from the host
// interface logic, and raw pin levels that are asynchronous to ref_clk.
`timescale 1ns/100ps
`include "pwm_logic_cfg.svh"

// Summary of operation
// RL1 - Off-time count held in two byte registers
// RL2 - On-time count held in two byte registers
// RL3 - Counts commit only on on-time high write
// RL4 - Counts advance on 2 us oscillator steps
// RL5 - Result inverted when output invert set
// RL6 - Each input optionally inverted before function
// RL7 - Function select picks off/AND/OR/XOR/flop/pass
// RL8 - Set bit forces logic flop high unless clear bit set
// RL9 - Clear bit forces logic flop low
// RL10 - Result debounced unless bypass bit set
// RL11 - Event enable gates event strobe and interrupt only
// RL12 - Level bit chooses active output level
// RL13 - Row 3 becomes input C or PWM
// RL14 - Row 0 drives logic result when selected
// RL15 - PWM repeats high on-time then low off-time
// RL16 - Function off holds result low
// RL17 - Flop data A, clocked by B rising
module pwm_logic_block (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire pwm_logic_pkg::reg_req_type reg_req,
  output logic [7:0]                      reg_rdata,
  input  wire logic                       logic_input_a,
  input  wire logic                       logic_input_b,
  input  wire logic                       row3_in,
  output logic                            row3_out,
  output logic                            row3_oe,
  input  wire logic                       gpio4_out,
  input  wire logic                       gpio4_oe,
  output logic                            row0_out,
  output logic                            row0_oe,
  input  wire logic                       gpio1_out,
  input  wire logic                       gpio1_oe,
  output logic                            logic_result_out,
  output logic                            pwm_out,
  output logic                            logic_event_strobe,
  output logic                            logic_event_active,
  output logic                            logic_int_active
);

  logic [7:0]  off_lo_r;
  logic [7:0]  off_hi_r;
  logic [7:0]  on_lo_r;
  logic [7:0]  on_hi_r;
  logic        pwm_en_r;
  logic [6:0]  func_r;
  logic [1:0]  flop_ctl_r;
  logic [2:0]  evt_ctl_r;
  logic [1:0]  row3_alt_function;
  logic        row0_alt_function;
  logic [15:0] on_act_r;
  logic [15:0] off_act_r;
  logic        commit;
  logic [5:0]  step_cnt_r;
  logic        step;
  pwm_logic_pkg::pwm_state_type pwm_state_r;
  logic [15:0] phase_cnt_r;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        b_prev_r;
  logic        in_a;
  logic        in_b;
  logic        in_c;
  logic        flop_r;
  logic        raw_result;
  logic        deb_r;
  logic        deb_prev_r;
  logic [3:0]  stable_cnt_r;
  logic        wr_ok;

  assign wr_ok  = reg_req.wr;
  assign commit = wr_ok && (reg_req.addr == `ADDR_ON_HI);

  // Register writes
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      off_lo_r          <= `RST_BYTE;
      off_hi_r          <= `RST_BYTE;
      on_lo_r           <= `RST_BYTE;
      on_hi_r           <= `RST_BYTE;
      pwm_en_r          <= 1'b0;
      func_r            <= 7'h00;
      flop_ctl_r        <= 2'h0;
      evt_ctl_r         <= 3'h0;
      row3_alt_function <= `RST_PIN_ALT;
      row0_alt_function <= 1'b0;
    end else if (wr_ok) begin
      if (reg_req.addr == `ADDR_OFF_LO) begin
        off_lo_r <= reg_req.wdata; // RL1
      end else if (reg_req.addr == `ADDR_OFF_HI) begin
        off_hi_r <= reg_req.wdata; // RL1
      end else if (reg_req.addr == `ADDR_ON_LO) begin
        on_lo_r <= reg_req.wdata; // RL2
      end else if (reg_req.addr == `ADDR_ON_HI) begin
        on_hi_r <= reg_req.wdata; // RL2
      end else if (reg_req.addr == `ADDR_PWM_CFG) begin
        pwm_en_r <= reg_req.wdata[`BIT_PWM_EN];
      end else if (reg_req.addr == `ADDR_FUNC_CFG) begin
        func_r <= reg_req.wdata[6:0];
      end else if (reg_req.addr == `ADDR_FLOP_CTL) begin
        flop_ctl_r <= reg_req.wdata[1:0];
      end else if (reg_req.addr == `ADDR_EVT_CTL) begin
        evt_ctl_r <= reg_req.wdata[2:0];
      end else if (reg_req.addr == `ADDR_PIN_EXT) begin
        row3_alt_function <= reg_req.wdata[`R3_HI:`R3_LO];
        row0_alt_function <= reg_req.wdata[`BIT_R0_ALT];
      end
    end
  end

  // Register reads, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_req.rd) begin
      if (reg_req.addr == `ADDR_OFF_LO) begin
        reg_rdata <= off_lo_r;
      end else if (reg_req.addr == `ADDR_OFF_HI) begin
        reg_rdata <= off_hi_r;
      end else if (reg_req.addr == `ADDR_ON_LO) begin
        reg_rdata <= on_lo_r;
      end else if (reg_req.addr == `ADDR_ON_HI) begin
        reg_rdata <= on_hi_r;
      end else if (reg_req.addr == `ADDR_PWM_CFG) begin
        reg_rdata <= {pwm_out, 6'h00, pwm_en_r};
      end else if (reg_req.addr == `ADDR_FUNC_CFG) begin
        reg_rdata <= {1'b0, func_r};
      end else if (reg_req.addr == `ADDR_FLOP_CTL) begin
        reg_rdata <= {flop_r, 5'h00, flop_ctl_r};
      end else if (reg_req.addr == `ADDR_EVT_CTL) begin
        reg_rdata <= {deb_r, 4'h0, evt_ctl_r};
      end else if (reg_req.addr == `ADDR_PIN_EXT) begin
        reg_rdata <= {4'h0, row3_alt_function, 1'b0, row0_alt_function};
      end else begin
        reg_rdata <= `RST_BYTE;
      end
    end
  end

  // Active counts change only on the on-time high byte write
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      on_act_r  <= `RST_COUNT;
      off_act_r <= `RST_COUNT;
    end else if (commit) begin
      on_act_r  <= {reg_req.wdata, on_lo_r}; // RL3
      off_act_r <= {off_hi_r, off_lo_r};     // RL3
    end
  end

  // 2 us step enable
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      step_cnt_r <= 6'h00;
    end else if (step) begin
      step_cnt_r <= 6'h00;
    end else begin
      step_cnt_r <= step_cnt_r + 6'h01;
    end
  end
  assign step = (step_cnt_r == 6'(`PWM_STEP_CYCLES - 1)); // RL4

  // PWM phase sequencer; a zero count lasts one step
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pwm_state_r <= pwm_logic_pkg::PWM_IDLE;
      phase_cnt_r <= `RST_COUNT;
    end else if (!pwm_en_r) begin
      pwm_state_r <= pwm_logic_pkg::PWM_IDLE;
      phase_cnt_r <= `RST_COUNT;
    end else begin
      case (pwm_state_r)
        pwm_logic_pkg::PWM_IDLE: begin
          pwm_state_r <= pwm_logic_pkg::PWM_HIGH;
          phase_cnt_r <= on_act_r;
        end
        pwm_logic_pkg::PWM_HIGH: begin
          if (step && phase_cnt_r <= 16'h0001) begin
            pwm_state_r <= pwm_logic_pkg::PWM_LOW; // RL15
            phase_cnt_r <= off_act_r;
          end else if (step) begin
            phase_cnt_r <= phase_cnt_r - 16'h0001; // RL4
          end
        end
        pwm_logic_pkg::PWM_LOW: begin
          if (step && phase_cnt_r <= 16'h0001) begin
            pwm_state_r <= pwm_logic_pkg::PWM_HIGH; // RL15
            phase_cnt_r <= on_act_r;
          end else if (step) begin
            phase_cnt_r <= phase_cnt_r - 16'h0001;
          end
        end
        default: begin
          pwm_state_r <= pwm_logic_pkg::PWM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= pwm_en_r && (pwm_state_r == pwm_logic_pkg::PWM_HIGH);
    end
  end

  // Two-flop synchronisers for pin inputs A, B and row 3
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {row3_in, logic_input_b, logic_input_a};
      sync2_r <= sync1_r;
    end
  end

  assign in_a = sync2_r[0] ^ func_r[`BIT_A_INV]; // RL6
  assign in_b = sync2_r[1] ^ func_r[`BIT_B_INV]; // RL6
  assign in_c = ((row3_alt_function == `R3_AS_INPUT_C) && sync2_r[2])
                ^ func_r[`BIT_C_INV]; // RL13 RL6

  // Logic flop: data A on rising B; clear beats set
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flop_r   <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      b_prev_r <= in_b;
      if (flop_ctl_r[`BIT_FLOP_CLR]) begin
        flop_r <= 1'b0; // RL9
      end else if (flop_ctl_r[`BIT_FLOP_SET]) begin
        flop_r <= 1'b1; // RL8
      end else if (in_b && !b_prev_r) begin
        flop_r <= in_a; // RL17
      end
    end
  end

  always_comb begin
    case (func_r[`SEL_HI:0])
      `SEL_AND:    raw_result = in_a & in_b & in_c; // RL7
      `SEL_OR:     raw_result = in_a | in_b | in_c;
      `SEL_XOR:    raw_result = in_a ^ in_b ^ in_c;
      `SEL_FLOP:   raw_result = flop_r;
      `SEL_PASS_A: raw_result = in_a;
      `SEL_PASS_B: raw_result = in_b;
      `SEL_PASS_C: raw_result = in_c;
      default:     raw_result = 1'b0; // RL16
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      logic_result_out <= 1'b0;
    end else begin
      logic_result_out <= raw_result ^ func_r[`BIT_RES_INV]; // RL5
    end
  end

  // Debounce: level must hold for several steps unless bypassed
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      deb_r        <= 1'b0;
      stable_cnt_r <= 4'h0;
    end else if (evt_ctl_r[`BIT_DBNC_BYP]) begin
      deb_r        <= logic_result_out; // RL10
      stable_cnt_r <= 4'h0;
    end else if (logic_result_out == deb_r) begin
      stable_cnt_r <= 4'h0;
    end else if (step && stable_cnt_r == `DBNC_STEPS - 4'h1) begin
      deb_r        <= logic_result_out; // RL10
      stable_cnt_r <= 4'h0;
    end else if (step) begin
      stable_cnt_r <= stable_cnt_r + 4'h1;
    end
  end

  // Events on each debounced change while enabled
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      deb_prev_r         <= 1'b0;
      logic_event_strobe <= 1'b0;
      logic_event_active <= 1'b0;
      logic_int_active   <= 1'b0;
    end else begin
      deb_prev_r         <= deb_r;
      logic_event_strobe <= evt_ctl_r[`BIT_EVT_EN] && (deb_r != deb_prev_r); // RL11
      logic_event_active <= (deb_r == evt_ctl_r[`BIT_INT_LVL]); // RL12
      logic_int_active   <= evt_ctl_r[`BIT_EVT_EN] && (deb_r == evt_ctl_r[`BIT_INT_LVL]); // RL11 RL12
    end
  end

  // Pin routing
  always_comb begin
    if (row3_alt_function == `R3_AS_PWM) begin
      row3_out = pwm_out; // RL13
      row3_oe  = 1'b1;
    end else if (row3_alt_function == `R3_AS_INPUT_C) begin
      row3_out = 1'b0;
      row3_oe  = 1'b0;
    end else begin
      row3_out = gpio4_out;
      row3_oe  = gpio4_oe;
    end
    if (row0_alt_function) begin
      row0_out = logic_result_out; // RL14
      row0_oe  = 1'b1;
    end else begin
      row0_out = gpio1_out;
      row0_oe  = gpio1_oe;
    end
  end

  sequence seq_high_ends;
    pwm_state_r == pwm_logic_pkg::PWM_HIGH && pwm_en_r && step && phase_cnt_r <= 16'h0001;
  endsequence

  sequence seq_on_commit;
    commit && pwm_en_r;
  endsequence

  chk_commit_latch: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
    seq_on_commit |=> on_act_r == {$past(reg_req.wdata), on_lo_r})
    else $error("on-time not committed on high byte write");

  chk_no_early_commit: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
    (wr_ok && reg_req.addr == `ADDR_OFF_LO) |=> $stable(off_act_r))
    else $error("off-time changed before commit");

  chk_off_pair: assert property (@(posedge ref_clk) disable iff (!rstn) // RL1
    commit |=> off_act_r == {off_hi_r, off_lo_r})
    else $error("off-time bytes paired wrongly");

  chk_step_period: assert property (@(posedge ref_clk) disable iff (!rstn) // RL4
    step |=> !step [*8] ##31 !step ##1 step)
    else $error("step period is not 40 cycles");

  chk_phase_switch: assert property (@(posedge ref_clk) disable iff (!rstn) // RL15
    seq_high_ends |=> pwm_state_r == pwm_logic_pkg::PWM_LOW && phase_cnt_r == $past(off_act_r) ##1 !pwm_out)
    else $error("high phase did not hand over to low");

  chk_result_invert: assert property (@(posedge ref_clk) disable iff (!rstn) // RL5
    $changed(func_r[`BIT_RES_INV]) && $stable(raw_result) |=> $changed(logic_result_out))
    else $error("result invert not applied");

  chk_off_mode: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    (func_r[`SEL_HI:0] == `SEL_OFF) |=> logic_result_out == $past(func_r[`BIT_RES_INV]))
    else $error("off function not held low");

  chk_flop_clear: assert property (@(posedge ref_clk) disable iff (!rstn) // RL9
    flop_ctl_r[`BIT_FLOP_CLR] |=> !flop_r)
    else $error("flop not cleared");

  chk_flop_set: assert property (@(posedge ref_clk) disable iff (!rstn) // RL8
    flop_ctl_r == 2'h2 |=> flop_r)
    else $error("flop not set");

  chk_event_gate: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
    logic_event_strobe |-> $past(evt_ctl_r[`BIT_EVT_EN]) && $past(deb_r) != $past(deb_prev_r))
    else $error("event without enable or change");

  chk_dbnc_bypass: assert property (@(posedge ref_clk) disable iff (!rstn) // RL10
    evt_ctl_r[`BIT_DBNC_BYP] |=> deb_r == $past(logic_result_out))
    else $error("bypass did not pass result");

  chk_row0_route: assert property (@(posedge ref_clk) disable iff (!rstn) // RL14
    row0_alt_function |-> row0_oe && row0_out == logic_result_out)
    else $error("row 0 not carrying result");

endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the PWM generator and logic block.
// Assumes the rtl folder is on the include path for the register map header.
`timescale 1ns/100ps
`include "pwm_logic_cfg.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
  logic                       ref_clk;
  logic                       rstn;
  pwm_logic_pkg::reg_req_type reg_req;
  logic [7:0]                 reg_rdata;
  logic                       in_a, in_b, row3_in, gpio4_out, gpio4_oe, gpio1_out, gpio1_oe;
  logic                       row3_out, row3_oe, row0_out, row0_oe, lro, pwm_out, evs, eva, inta;
  int                         errors, compares, n;
  logic [7:0]                 v;
  logic [7:0]                 amap [10] = '{8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h3A, 8'h40};

  pwm_logic_block uut (.ref_clk(ref_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .logic_input_a(in_a), .logic_input_b(in_b), .row3_in(row3_in), .row3_out(row3_out),
    .row3_oe(row3_oe), .gpio4_out(gpio4_out), .gpio4_oe(gpio4_oe), .row0_out(row0_out),
    .row0_oe(row0_oe), .gpio1_out(gpio1_out), .gpio1_oe(gpio1_oe), .logic_result_out(lro),
    .pwm_out(pwm_out), .logic_event_strobe(evs), .logic_event_active(eva), .logic_int_active(inta));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pins(input logic [2:0] x);
    @(posedge ref_clk);
    {row3_in, in_b, in_a} <= x;
  endtask

  // Counts settled cycles until pwm_out reaches the level; a hang ends the run
  task automatic wait_pwm(input logic lv, output int k);
    k = 0;
    while (pwm_out !== lv && k < 20000) begin
      cyc(1);
      k++;
    end
    if (k >= 20000) begin
      errors++;
      $display("BAD pwm_wait expected %0h seen %0h", lv, pwm_out);
      give_verdict;
    end
  endtask

  // Lines up on a fall, which sits on a step, then measures a whole low phase and the high one after it
  task automatic pwm_check(input int hi, input int lo);
    int k;
    cyc(1);
    wait_pwm(1'b1, k);
    wait_pwm(1'b0, k);
    wait_pwm(1'b1, k);
    `CHK("pwm_low_cycles", lo, k)
    wait_pwm(1'b0, k);
    `CHK("pwm_high_cycles", hi, k)
  endtask

  task automatic count_strobe(input int bound, output int k);
    k = 0;
    while (evs !== 1'b1 && k < bound) begin
      cyc(1);
      k++;
    end
  endtask

  function automatic logic lexp(input logic [2:0] s, input logic [3:0] iv, input logic [2:0] x);
    logic [2:0] y;
    logic       r;
    y = x ^ iv[2:0];
    case (s)
      3'h0: r = 1'b0;
      3'h1: r = &y;
      3'h2: r = |y;
      3'h3: r = ^y;
      3'h5: r = y[0];
      3'h6: r = y[1];
      default: r = y[2];
    endcase
    return r ^ iv[3];
  endfunction

  initial begin
    reg_req = '0;
    {in_a, in_b, row3_in} = 3'h0;
    {gpio4_out, gpio4_oe, gpio1_out, gpio1_oe} = 4'hA;
    errors = 0;
    compares = 0;
    rstn = 1'b0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    cyc(2);
    for (int i = 0; i < 10; i++) begin
      rd(amap[i], v);
      `CHK("reset_value", 8'h00, v)
    end
    `CHK("row0_out_gpio", gpio1_out, row0_out)
    `CHK("row3_oe_gpio", gpio4_oe, row3_oe)
    wr(`ADDR_OFF_LO, 8'hA5);
    wr(`ADDR_OFF_HI, 8'h5A);
    wr(`ADDR_ON_LO, 8'hC3);
    wr(`ADDR_FUNC_CFG, 8'hFF);
    rd(`ADDR_OFF_LO, v);
    `CHK("off_time_byte_lo", 8'hA5, v)
    rd(`ADDR_OFF_HI, v);
    `CHK("off_time_byte_hi", 8'h5A, v)
    rd(`ADDR_ON_LO, v);
    `CHK("on_time_byte_lo", 8'hC3, v)
    rd(`ADDR_FUNC_CFG, v);
    `CHK("function_cfg", 8'h7F, v)
    // Row 3 as input C, row 0 carries the logic result
    wr(`ADDR_PIN_EXT, 8'h05);
    gpio4_oe <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      if (s == 4) continue;
      for (int iv = 0; iv < 16; iv++) begin
        wr(`ADDR_FUNC_CFG, {1'b0, iv[3:0], s[2:0]});
        for (int x = 0; x < 8; x++) begin
          pins(x[2:0]);
          cyc(6);
          `CHK("logic_result_out", lexp(s[2:0], iv[3:0], x[2:0]), lro)
          `CHK("row0_out_result", lexp(s[2:0], iv[3:0], x[2:0]), row0_out)
        end
      end
    end
    `CHK("row3_oe_input", 1'b0, row3_oe)
    wr(`ADDR_FUNC_CFG, {5'h00, `SEL_FLOP});
    wr(`ADDR_FLOP_CTL, 8'h02);
    cyc(4);
    `CHK("flop_set", 1'b1, lro)
    rd(`ADDR_FLOP_CTL, v);
    `CHK("flop_ctl_read", 8'h82, v)
    wr(`ADDR_FLOP_CTL, 8'h03);
    cyc(4);
    `CHK("flop_clear", 1'b0, lro)
    wr(`ADDR_FLOP_CTL, 8'h00);
    pins(3'h1);
    cyc(6);
    `CHK("flop_hold", 1'b0, lro)
    pins(3'h3);
    cyc(6);
    `CHK("flop_clocked_one", 1'b1, lro)
    pins(3'h0);
    cyc(6);
    pins(3'h2);
    cyc(6);
    `CHK("flop_clocked_zero", 1'b0, lro)
    // Debounced event on a rising pass-through of input A
    wr(`ADDR_FUNC_CFG, {5'h00, `SEL_PASS_A});
    wr(`ADDR_EVT_CTL, 8'h02);
    cyc(300);
    pins(3'h1);
    count_strobe(400, n);
    `CHK("debounce_slow", 1'b1, n > (`DBNC_STEPS - 1) * `PWM_STEP_CYCLES + 4 && n <= `DBNC_STEPS * `PWM_STEP_CYCLES + 4)
    rd(`ADDR_EVT_CTL, v);
    `CHK("event_ctl_read", 8'h82, v)
    `CHK("active_low_level", 1'b0, eva)
    wr(`ADDR_EVT_CTL, 8'h03);
    cyc(3);
    `CHK("active_high_level", 1'b1, eva)
    `CHK("int_active", 1'b1, inta)
    wr(`ADDR_EVT_CTL, 8'h07);
    pins(3'h0);
    count_strobe(20, n);
    `CHK("bypass_fast", 1'b1, n < 10)
    wr(`ADDR_EVT_CTL, 8'h05);
    pins(3'h1);
    count_strobe(20, n);
    `CHK("no_event_disabled", 20, n)
    `CHK("no_int_disabled", 1'b0, inta)
    // PWM on 3 steps, off 2 steps, routed to row 3
    wr(`ADDR_PIN_EXT, 8'h08);
    gpio4_oe <= 1'b0;
    wr(`ADDR_OFF_LO, 8'h02);
    wr(`ADDR_OFF_HI, 8'h00);
    wr(`ADDR_ON_LO, 8'h03);
    wr(`ADDR_ON_HI, 8'h00);
    wr(`ADDR_PWM_CFG, 8'h01);
    pwm_check(3 * `PWM_STEP_CYCLES, 2 * `PWM_STEP_CYCLES);
    `CHK("row3_pwm_oe", 1'b1, row3_oe)
    `CHK("row3_pwm_out", 1'b0, row3_out)
    wr(`ADDR_OFF_LO, 8'h04);
    wr(`ADDR_ON_LO, 8'h01);
    pwm_check(3 * `PWM_STEP_CYCLES, 2 * `PWM_STEP_CYCLES);
    wr(`ADDR_ON_HI, 8'h00);
    pwm_check(1 * `PWM_STEP_CYCLES, 4 * `PWM_STEP_CYCLES);
    wr(`ADDR_PWM_CFG, 8'h00);
    cyc(4);
    `CHK("pwm_disabled", 1'b0, pwm_out)
    give_verdict;
  end
endmodule
